//--- pkg/timer_pkg.sv
// Purpose: Shared constants and types for the timer/counter block
// Assumes: 32-bit classic Wishbone slave, word-aligned registers
// Notes: Offsets are byte addresses
package timer_pkg;
	localparam int CNT_W = 16;
	localparam int PRE_W = 10;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_TOP = 8'h04;
	localparam logic [7:0] OFS_CMP = 8'h08;
	localparam logic [7:0] OFS_COUNT = 8'h0C;
	localparam logic [7:0] OFS_CAPT = 8'h10;
	localparam logic [7:0] OFS_STAT = 8'h14;
	localparam logic [7:0] OFS_IMASK = 8'h18;
	localparam logic [7:0] OFS_ICLR = 8'h1C;
	// Control field positions
	localparam int CTRL_EN = 0;
	localparam int CTRL_MODE_LO = 1;
	localparam int CTRL_SRC = 3;
	localparam int CTRL_PRE_LO = 4;
	localparam int CTRL_CAPEN = 7;
	localparam int CTRL_INV = 8;
	localparam int CTRL_USEBUS = 9;
	// Status bit positions
	localparam int ST_OVF = 0;
	localparam int ST_CMP = 1;
	localparam int ST_CAP = 2;
	// Reset values
	localparam logic [15:0] TOP_RST = 16'hFFFF;
	localparam logic [15:0] CMP_RST = 16'h8000;
	localparam logic [2:0] MASK_RST = 3'h0;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

	typedef enum logic [1:0] {
		MODE_WDOG = 2'b00,
		MODE_CTC = 2'b01,
		MODE_FPWM = 2'b10,
		MODE_PFC = 2'b11
	} mode_t;

	typedef struct packed {
		logic inv;
		logic capen;
		logic [2:0] pre;
		logic src;
		mode_t mode;
		logic en;
	} ctrl_t;

	typedef struct packed {
		logic cap;
		logic cmp;
		logic ovf;
	} events_t;
endpackage

//--- hdl/timer_prescaler.sv
// Purpose: Clock source select and power-of-two prescaler producing count ticks
// Assumes: Timer input clock is synchronous to the system clock
// Notes: Tick is a one-cycle pulse on the system clock
`timescale 1ns/1ps
module timer_prescaler
	import timer_pkg::*;
#(
	parameter int PW = PRE_W
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic run_i,
	input wire logic src_i,
	input wire logic [2:0] sel_i,
	input wire logic ext_clk_i,
	output logic tick_o
);
	logic ext_q;
	logic [PW-1:0] div;
	logic src_tick;
	logic [PW-1:0] div_mask;
	// Source 0 is every system clock, source 1 is rising edges of the timer clock
	assign src_tick = src_i ? (ext_clk_i & ~ext_q) : 1'b1;
	// Division by 2^(sel) using low bits of a free counter
	assign div_mask = PW'((1 << sel_i) - 1);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ext_q <= 1'b0;
			div <= '0;
			tick_o <= 1'b0;
		end else begin
			ext_q <= ext_clk_i;
			tick_o <= run_i && src_tick && ((div & div_mask) == div_mask);
			if (!run_i)
				div <= '0;
			else if (src_tick)
				div <= div + 1'b1;
		end
	end
endmodule

//--- hdl/timer_counter.sv
// Purpose: 16-bit up/down timer with compare, PWM, capture and Wishbone registers
// Assumes: All inputs synchronous to MCLK_I; classic Wishbone, one-wait ack
// Notes: Stand-alone mode uses preload parameters when bus use is off
// Behaviour
// R1: 16-bit counter counts up and down
// R2: Watchdog, clear-on-compare, fast PWM, phase-correct PWM
// R3: Selectable clock source and prescaler
// R4: Independent compare drives the wave output
// R5: Glitch-free PWM with buffered period updates
// R6: Overflow, compare, capture interrupt causes
// R7: Synchronised rising capture edge stores count
// R8: Capture only non-PWM and with bus
// R9: Without bus, interrupt is overflow flag
// R10: With bus, interrupt gated by three mask bits
// R11: Reset pin enable preloaded, always honoured
// R12: Stand-alone runs from preloaded control values
// R13: Wake-up request plus static interrupt output
// R14: Registers reachable by Wishbone master
// R15: Counter reloads automatically each period
// R16: Overflow flag sticky until cleared
`timescale 1ns/1ps
module timer_counter
	import timer_pkg::*;
#(
	parameter logic [8:0] PRELOAD_CTRL = 9'h001,
	parameter logic [15:0] PRELOAD_TOP = TOP_RST,
	parameter logic [15:0] PRELOAD_CMP = CMP_RST
) (
	input wire logic MCLK_I,
	input wire logic RESET_N_I,
	input wire logic TIMER_INPUT_CLOCK_I,
	input wire logic TIMER_RESET_N_I,
	input wire logic CAPTURE_TRIGGER_IN_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic WB_WE_I,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	output logic TIMER_IRQ_OUT_O,
	output logic TIMER_WAVE_OUT_O,
	output logic WAKE_REQ_O
);
	// Register state
	logic [9:0] ctrl_reg;
	logic [15:0] top_reg;
	logic [15:0] cmp_reg;
	logic [15:0] top_act;
	logic [15:0] cmp_act;
	logic [15:0] current_count;
	logic [15:0] capture_value_reg;
	events_t stat;
	logic [2:0] imask;
	logic dir_down;
	logic wave;
	logic cap_s1;
	logic cap_s2;
	logic cap_s3;
	logic reset_pin_enable;

	// Decoding
	wire logic use_bus = ctrl_reg[CTRL_USEBUS];
	wire ctrl_t ctl = use_bus ? ctrl_t'(ctrl_reg[8:0]) : ctrl_t'(PRELOAD_CTRL); // R12
	wire logic [15:0] top_src = use_bus ? top_reg : PRELOAD_TOP;
	wire logic [15:0] cmp_src = use_bus ? cmp_reg : PRELOAD_CMP;
	wire logic is_pwm = (ctl.mode == MODE_FPWM) || (ctl.mode == MODE_PFC);
	wire logic bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	wire logic wr = bus_req && WB_WE_I;
	wire logic wr_lo = wr && WB_SEL_I[0];
	wire logic wr_hi = wr && WB_SEL_I[1];
	wire logic tick;
	wire logic timer_rst = reset_pin_enable && !TIMER_RESET_N_I; // R11
	wire logic run = ctl.en && !timer_rst;

	// Period end and direction change
	wire logic at_top = (current_count == top_act);
	wire logic at_zero = (current_count == 16'h0000);
	wire logic period_end = tick && ((ctl.mode == MODE_PFC) ? (dir_down && at_zero) : at_top);
	wire logic cmp_hit = tick && (current_count == cmp_act);
	wire logic ovf_hit = period_end; // R16
	wire logic cap_edge = cap_s2 && !cap_s3;
	wire logic cap_hit = cap_edge && ctl.capen && !is_pwm && use_bus; // R8
	wire logic [15:0] count_top = (ctl.mode == MODE_WDOG) ? 16'hFFFF : top_act;

	// Next counter value: reload at end of period, bounce in phase-correct mode
	logic [15:0] next_count;
	logic next_dir;
	always_comb begin
		next_count = current_count;
		next_dir = dir_down;
		if (!run) begin
			next_count = 16'h0000;
			next_dir = 1'b0;
		end else if (tick) begin
			if (ctl.mode == MODE_PFC) begin // R1
				if (!dir_down && current_count >= top_act) begin
					next_dir = 1'b1;
					next_count = current_count - 16'h0001;
				end else if (dir_down && at_zero) begin
					next_dir = 1'b0;
					next_count = 16'h0001;
				end else if (dir_down) begin
					next_count = current_count - 16'h0001;
				end else begin
					next_count = current_count + 16'h0001;
				end
			end else if (current_count >= count_top) begin
				next_count = 16'h0000; // R15
			end else if (ctl.mode == MODE_CTC && current_count == cmp_act) begin
				next_count = 16'h0000; // R2
			end else begin
				next_count = current_count + 16'h0001;
			end
		end
	end

	// Wave output: set/clear per mode, compare and top shadowed for glitch-free PWM
	logic next_wave;
	always_comb begin
		next_wave = wave;
		if (!run)
			next_wave = 1'b0;
		else if (tick) begin
			unique case (ctl.mode)
				MODE_WDOG: next_wave = wave; // R4
				MODE_CTC: next_wave = (current_count == cmp_act) ? ~wave : wave;
				MODE_FPWM: next_wave = (next_count < cmp_act); // R5
				MODE_PFC: next_wave = (next_count < cmp_act);
			endcase
		end
	end

	wire logic [2:0] ev_bits = {cap_hit, cmp_hit, ovf_hit};
	wire logic [2:0] clr_bits = (wr && WB_SEL_I[0] && WB_ADR_I == OFS_ICLR) ? WB_DAT_I[2:0] : 3'h0;

	// Timer core state
	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			current_count <= 16'h0000;
			dir_down <= 1'b0;
			wave <= 1'b0;
			top_act <= TOP_RST;
			cmp_act <= CMP_RST;
		end else begin
			current_count <= next_count;
			dir_down <= next_dir;
			wave <= next_wave;
			// In PWM modes shadow update only at period boundary or when stopped, so PWM never glitches
			if (!run || period_end || !is_pwm) begin // R5
				top_act <= top_src;
				cmp_act <= cmp_src;
			end
		end
	end

	// Capture synchroniser and time stamp
	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			cap_s1 <= 1'b0;
			cap_s2 <= 1'b0;
			cap_s3 <= 1'b0;
			capture_value_reg <= 16'h0000;
		end else begin
			cap_s1 <= CAPTURE_TRIGGER_IN_I; // R7
			cap_s2 <= cap_s1;
			cap_s3 <= cap_s2;
			if (cap_hit)
				capture_value_reg <= current_count; // R7
		end
	end

	// Sticky event flags, set wins over clear
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : gen_flag
			always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
				if (!RESET_N_I)
					stat[g] <= 1'b0;
				else if (ev_bits[g]) // R6
					stat[g] <= 1'b1;
				else if (clr_bits[g]) // R16
					stat[g] <= 1'b0;
			end
		end
	endgenerate

	// Software registers; reset pin enable is preloaded and not writable
	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			ctrl_reg <= {1'b1, PRELOAD_CTRL}; // R14
			top_reg <= TOP_RST;
			cmp_reg <= CMP_RST;
			imask <= MASK_RST;
			reset_pin_enable <= 1'b1; // R11
		end else begin
			reset_pin_enable <= 1'b1;
			if (WB_ADR_I == OFS_CTRL && wr_lo)
				ctrl_reg[7:0] <= WB_DAT_I[7:0];
			if (WB_ADR_I == OFS_CTRL && wr_hi)
				ctrl_reg[9:8] <= WB_DAT_I[9:8];
			if (WB_ADR_I == OFS_TOP && wr_lo)
				top_reg[7:0] <= WB_DAT_I[7:0];
			if (WB_ADR_I == OFS_TOP && wr_hi)
				top_reg[15:8] <= WB_DAT_I[15:8];
			if (WB_ADR_I == OFS_CMP && wr_lo)
				cmp_reg[7:0] <= WB_DAT_I[7:0];
			if (WB_ADR_I == OFS_CMP && wr_hi)
				cmp_reg[15:8] <= WB_DAT_I[15:8];
			if (WB_ADR_I == OFS_IMASK && wr_lo)
				imask <= WB_DAT_I[2:0];
		end
	end

	// Read multiplexer; unmapped addresses read zero and still ack
	logic [31:0] rd_data;
	always_comb begin
		unique case (WB_ADR_I)
			OFS_CTRL: rd_data = {22'h0, ctrl_reg};
			OFS_TOP: rd_data = {16'h0, top_reg};
			OFS_CMP: rd_data = {16'h0, cmp_reg};
			OFS_COUNT: rd_data = {16'h0, current_count};
			OFS_CAPT: rd_data = {16'h0, capture_value_reg};
			OFS_STAT: rd_data = {29'h0, stat};
			OFS_IMASK: rd_data = {29'h0, imask};
			default: rd_data = UNMAPPED_DATA;
		endcase
	end

	// Bus answer and interrupt outputs, all registered
	wire logic irq_next = use_bus ? |(stat & imask) : stat.ovf; // R9 R10
	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0000_0000;
			TIMER_IRQ_OUT_O <= 1'b0;
			TIMER_WAVE_OUT_O <= 1'b0;
			WAKE_REQ_O <= 1'b0;
		end else begin
			WB_ACK_O <= bus_req; // R14
			WB_DAT_O <= bus_req ? rd_data : 32'h0000_0000;
			TIMER_IRQ_OUT_O <= irq_next; // R13
			TIMER_WAVE_OUT_O <= wave ^ ctl.inv; // R4
			WAKE_REQ_O <= irq_next; // R13
		end
	end

	timer_prescaler #(
		.PW(PRE_W)
	) u_pre (
		.clk_i(MCLK_I),
		.rst_n_i(RESET_N_I),
		.run_i(run),
		.src_i(ctl.src), // R3
		.sel_i(ctl.pre),
		.ext_clk_i(TIMER_INPUT_CLOCK_I),
		.tick_o(tick)
	);
endmodule

//--- verif/timer_counter_props.sv
// Purpose: Port-level checks of the timer block
// Assumes: Classic Wishbone, ack one cycle after a request
// Notes: Bound to every timer_counter instance
`timescale 1ns/1ps
module timer_counter_props (
	input wire logic MCLK_I,
	input wire logic RESET_N_I,
	input wire logic TIMER_RESET_N_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic WB_WE_I,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic WB_ACK_O,
	input wire logic TIMER_IRQ_OUT_O,
	input wire logic TIMER_WAVE_OUT_O,
	input wire logic WAKE_REQ_O
);
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!RESET_N_I);
	// A request taken but not yet answered
	sequence req_s;
		WB_CYC_I && WB_STB_I && !WB_ACK_O;
	endsequence
	sequence idle_s;
		!(WB_CYC_I && WB_STB_I);
	endsequence
	// Reads beyond the map must come back empty
	sequence hole_rd_s;
		req_s ##0 (!WB_WE_I && WB_ADR_I >= 8'h20);
	endsequence
	chk_ack_next: assert property (req_s |=> WB_ACK_O)
		else $error("ack not one cycle after request");
	chk_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	chk_ack_spur: assert property (idle_s ##1 idle_s |-> !WB_ACK_O)
		else $error("ack without request");
	chk_data_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0000_0000)
		else $error("read data outside ack");
	chk_hole_zero: assert property (hole_rd_s |=> WB_ACK_O && WB_DAT_O == 32'h0000_0000)
		else $error("unmapped read not zero");
	chk_wake_irq: assert property (WAKE_REQ_O == TIMER_IRQ_OUT_O)
		else $error("wake differs from irq");
	chk_pin_wave: assert property (!TIMER_RESET_N_I [*3] |-> !TIMER_WAVE_OUT_O)
		else $error("wave active in timer reset");
	chk_reset_out: assert property ($rose(RESET_N_I) |-> !WB_ACK_O && !TIMER_IRQ_OUT_O)
		else $error("outputs active after reset");
endmodule
bind timer_counter timer_counter_props u_timer_counter_props (.MCLK_I(MCLK_I),
	.RESET_N_I(RESET_N_I), .TIMER_RESET_N_I(TIMER_RESET_N_I), .WB_ADR_I(WB_ADR_I),
	.WB_WE_I(WB_WE_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O),
	.WB_ACK_O(WB_ACK_O), .TIMER_IRQ_OUT_O(TIMER_IRQ_OUT_O),
	.TIMER_WAVE_OUT_O(TIMER_WAVE_OUT_O), .WAKE_REQ_O(WAKE_REQ_O));

//--- verif/wb_host.sv
// Purpose: Fabric-side Wishbone master for the timer block
// Assumes: Classic single cycles, slave answers in its own time
// Notes: Released lines show inverted values so stale data is not trusted
`timescale 1ns/1ps
module wb_host (
	input wire logic clk_i,
	input wire logic ack_i,
	output logic [7:0] adr_o,
	output logic [31:0] dat_o,
	output logic [3:0] sel_o,
	output logic we_o,
	output logic cyc_o,
	output logic stb_o
);
	// Idle bus from time zero
	initial begin
		{cyc_o, stb_o, we_o, sel_o, adr_o, dat_o} = '0;
	end
	// Request held until ack is sampled high, then released for a cycle
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{cyc_o, stb_o, we_o, sel_o, adr_o, dat_o} <= {3'b110 | {2'b00, w}, 4'hF, a, d};
		do @(posedge clk_i); while (ack_i !== 1'b1);
		{cyc_o, stb_o, we_o, adr_o, dat_o} <= {3'b000, ~a, ~d};
		@(posedge clk_i);
	endtask
endmodule

//--- verif/timer_counter_tb.sv
// Purpose: Self-checking bench for the timer block
// Assumes: Stand-alone preload is fast PWM with a short period
// Notes: Read results are matched against queued notes
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin compares++; if ((sn) !== (ex)) begin errors++; \
	$display("[FAIL] %s exp %h got %h", nm, ex, sn); end end
module timer_counter_tb;
	import timer_pkg::*;
	logic clk, rst_n, tclk, trst_n, trig, we, cyc, stb, ack, irq, wave, wake;
	logic [7:0] adr;
	logic [31:0] wdat, rdat, v;
	logic [3:0] sel;
	logic [63:0] e;
	logic [63:0] exp_q[$];
	logic [15:0] top;
	int errors = 0;
	int compares = 0;
	timer_counter #(.PRELOAD_CTRL(9'h005), .PRELOAD_TOP(16'h0007)) u_timer_counter (
		.MCLK_I(clk), .RESET_N_I(rst_n), .TIMER_INPUT_CLOCK_I(tclk),
		.TIMER_RESET_N_I(trst_n), .CAPTURE_TRIGGER_IN_I(trig), .WB_ADR_I(adr),
		.WB_DAT_I(wdat), .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_DAT_O(rdat), .WB_ACK_O(ack), .TIMER_IRQ_OUT_O(irq),
		.TIMER_WAVE_OUT_O(wave), .WAKE_REQ_O(wake));
	wb_host u_wb_host (.clk_i(clk), .ack_i(ack), .adr_o(adr), .dat_o(wdat),
		.sel_o(sel), .we_o(we), .cyc_o(cyc), .stb_o(stb));
	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Each read answer is checked against the oldest note
	always @(posedge clk) begin
		if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			`CHK("read data", e[31:0], rdat & e[63:32])
		end
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_wb_host.xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		exp_q.push_back({m, x});
		u_wb_host.xfer(1'b0, a, 32'h0000_0000);
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Short trigger pulse, then time for the synchroniser
	task automatic pulse();
		trig <= 1'b1;
		wait_n(2);
		trig <= 1'b0;
		wait_n(6);
	endtask
	task automatic end_sim();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Watchdog sized well beyond the few hundred cycles the tests need
	initial begin
		#1_000_000;
		errors++;
		end_sim();
	end
	// Main sequence
	initial begin
		void'($urandom(88912));
		{rst_n, tclk, trst_n, trig} = 4'b0010;
		wait_n(3);
		rst_n <= 1'b1;
		// Bus mode bit plus the preload given to this instance
		rd(OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0205);
		rd(OFS_TOP, 32'hFFFF_FFFF, {16'h0000, TOP_RST});
		rd(OFS_CMP, 32'hFFFF_FFFF, {16'h0000, CMP_RST});
		rd(OFS_IMASK, 32'hFFFF_FFFF, 32'h0000_0000);
		wr(8'h24, 32'hFFFF_FFFF);
		rd(8'h24, 32'hFFFF_FFFF, 32'h0000_0000);
		$display("test reset values done");
		for (int m = 0; m < 4; m++) begin
			v = 32'h0000_0200 | (m << 1) | (($urandom % 8) << 4);
			wr(OFS_CTRL, v);
			rd(OFS_CTRL, 32'h0000_03FF, v);
		end
		$display("test modes done");
		top = 16'(4 + $urandom % 8);
		wr(OFS_TOP, {16'h0000, top});
		wr(OFS_ICLR, 32'h0000_0007);
		wr(OFS_CTRL, 32'h0000_0205);
		wait_n(3 * top);
		wr(OFS_CTRL, 32'h0000_0204);
		rd(OFS_STAT, 32'h0000_0001, 32'h0000_0001);
		rd(OFS_COUNT, 32'hFFFF_0000, 32'h0000_0000);
		`CHK("irq masked", 1'b0, irq)
		wr(OFS_IMASK, 32'h0000_0001);
		wait_n(2);
		`CHK("irq", 1'b1, irq)
		wr(OFS_ICLR, 32'h0000_0001);
		rd(OFS_STAT, 32'h0000_0001, 32'h0000_0000);
		wait_n(2);
		`CHK("irq cleared", 1'b0, irq)
		$display("test overflow done");
		wr(OFS_CTRL, 32'h0000_0209);
		trst_n <= 1'b0;
		wait_n(3);
		`CHK("wave in reset", 1'b0, wave)
		trst_n <= 1'b1;
		wait_n(8);
		rd(OFS_COUNT, 32'h0000_FFFF, 32'h0000_0000);
		for (int i = 0; i < 5; i++) begin
			tclk <= 1'b1;
			wait_n(2);
			tclk <= 1'b0;
			wait_n(2);
		end
		wait_n(4);
		rd(OFS_COUNT, 32'h0000_FFFF, 32'h0000_0005);
		$display("test source done");
		wr(OFS_CTRL, 32'h0000_0285);
		wr(OFS_ICLR, 32'h0000_0007);
		pulse();
		rd(OFS_STAT, 32'h0000_0004, 32'h0000_0000);
		wr(OFS_CTRL, 32'h0000_0281);
		wr(OFS_ICLR, 32'h0000_0007);
		pulse();
		rd(OFS_STAT, 32'h0000_0004, 32'h0000_0004);
		$display("test capture done");
		wr(OFS_IMASK, 32'h0000_0000);
		wr(OFS_ICLR, 32'h0000_0007);
		wr(OFS_CTRL, 32'h0000_0000);
		wait_n(30);
		`CHK("stand-alone irq", 1'b1, irq)
		`CHK("wake", 1'b1, wake)
		// Preloaded compare lies above the preloaded top, so the wave stays high
		`CHK("stand-alone wave", 1'b1, wave)
		$display("test stand-alone done");
		end_sim();
	end
endmodule
